// ===== aab_axil_slave.sv
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "aab_map.svh"

module aab_axil_slave (
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic [11:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [11:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output aab_pkg::aab_wr_type      wr,
	output aab_pkg::aab_sel_type     rd_sel,
	input  wire logic [7:0]          rd_data
);

	typedef struct packed {
		logic        awready;
		logic        aw_held;
		logic [11:0] aw_addr;
		logic        wready;
		logic        w_held;
		logic [7:0]  w_data;
		logic        w_lane0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} aab_slv_type;

	aab_slv_type st_r;
	aab_slv_type st_nxt;
	aab_pkg::aab_sel_type wr_sel;
	logic                 do_write;

	// a write fires once address and data are both held and no response is pending
	assign wr_sel   = aab_pkg::aab_decode(st_r.aw_addr);
	assign do_write = st_r.aw_held & st_r.w_held & ~st_r.bvalid;
	assign wr       = '{en: do_write & st_r.w_lane0 & (wr_sel != aab_pkg::AAB_SEL_NONE),
		sel: wr_sel, data: st_r.w_data};
	assign rd_sel   = aab_pkg::aab_decode(s_axi_araddr);

	// next state of both channels
	always_comb begin
		st_nxt = st_r;
		if (s_axi_awvalid & st_r.awready) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid & st_r.wready) begin
			st_nxt.w_held  = 1'b1;
			st_nxt.w_data  = s_axi_wdata[7:0];
			st_nxt.w_lane0 = s_axi_wstrb[0]; // data lives in byte lane 0 only
		end
		if (s_axi_bvalid & s_axi_bready)
			st_nxt.bvalid = 1'b0;
		if (do_write) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = (wr_sel == aab_pkg::AAB_SEL_NONE) ? `AAB_RESP_SLVERR : `AAB_RESP_OKAY;
		end
		// ready drops while a half is held, so a second write cannot overrun it
		st_nxt.awready = ~st_nxt.aw_held & ~st_nxt.bvalid;
		st_nxt.wready  = ~st_nxt.w_held & ~st_nxt.bvalid;
		if (s_axi_rvalid & s_axi_rready)
			st_nxt.rvalid = 1'b0;
		if (s_axi_arvalid & st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = {24'h0, rd_data};
			st_nxt.rresp  = (rd_sel == aab_pkg::AAB_SEL_NONE) ? `AAB_RESP_SLVERR : `AAB_RESP_OKAY;
		end
		st_nxt.arready = ~st_nxt.rvalid;
	end

	// channel state register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;

endmodule // aab_axil_slave
`default_nettype wire

// ===== aab_config_bank.sv
// aux converter enable and cell balancing configuration bank on axi4-lite
//
// Notes on behaviour
// R1: each aux enable bit set to 1 includes its source in aux conversions
// R2: software keeps cell-select off while under- or overvoltage threshold enable is set
// R3: duty unit bit 0 minutes, 1 seconds; should match cell timer unit
// R4: cell-1 time unit bit 0 minutes, 1 seconds
// R5: cell-1 balance time is seven bits counted in that unit
// R6: halt-on-fault 0 keeps balancing; 1 halts on a qualifying fault
// R7: order 00 odd, 01 even, 10 odd then even, 11 even then odd
// R8: reserved bits read zero and ignore writes

`timescale 1ns/1ps
`default_nettype none
`include "aab_map.svh"

module aab_config_bank (
	// one clock, asynchronous active-low reset
	input  wire logic                        sys_clk,
	input  wire logic                        arst_n,
	// axi4-lite register port
	input  wire logic [11:0]                 s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [11:0]                 s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// fault engine: a fault that qualifies for stopping balancing
	input  wire logic                        qualifying_fault,
	// configuration towards the aux converter and balancing engines
	output aab_pkg::aab_aux_b_type           aux_conv_b,
	output aab_pkg::aab_aux_c_type           aux_conv_c,
	output aab_pkg::aab_bal_setup_type       balance_cfg,
	output aab_pkg::aab_cell_timer_type      cell1_timer,
	// channel order decoded for the balancing sequencer
	output logic                             order_odd_first,
	output logic                             order_two_pass,
	// live state, also readable in the status register
	output logic                             balance_halted,
	output logic                             unit_mismatch
);

	// whole bank state in one record
	typedef struct packed {
		// software-visible registers
		aab_pkg::aab_aux_b_type      aux_b;
		aab_pkg::aab_aux_c_type      aux_c;
		aab_pkg::aab_bal_setup_type  bal;
		aab_pkg::aab_cell_timer_type cell1;
		// flags derived from the registers and the fault input, held in flops
		logic                        odd_first;
		logic                        two_pass;
		logic                        halted;
		logic                        mismatch;
	} aab_bank_type;

	aab_bank_type         bank_r;
	aab_bank_type         bank_nxt;
	// write strobe and read path shared with the bus slave
	aab_pkg::aab_wr_type  wr;
	aab_pkg::aab_sel_type rd_sel;
	logic [7:0]           rd_data;
	logic [7:0]           status_byte;

	// bus handshakes live in the slave; the bank sees at most one strobe per write
	// the strobe comes in the first cycle that both halves of a write are held
	aab_axil_slave u_slave (
		.sys_clk       (sys_clk),
		.arst_n        (arst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr            (wr),
		.rd_sel        (rd_sel),
		.rd_data       (rd_data)
	);

	// status: live state of the bank, read only
	// reading it has no side effect; only a setup write clears the halt
	always_comb begin
		status_byte = 8'h00;
		status_byte[`AAB_STAT_HALTED]   = bank_r.halted;
		status_byte[`AAB_STAT_MISMATCH] = bank_r.mismatch;
	end

	// read mux; unmapped addresses read zero
	// kept combinational from the flops: the slave captures it at the edge the
	// read address is taken; reserved bits are zero in the flops [R8]
	always_comb begin
		unique case (rd_sel)
			aab_pkg::AAB_SEL_AUX_B:  rd_data = bank_r.aux_b;
			aab_pkg::AAB_SEL_AUX_C:  rd_data = bank_r.aux_c;
			aab_pkg::AAB_SEL_BAL:    rd_data = bank_r.bal;
			aab_pkg::AAB_SEL_CELL1:  rd_data = bank_r.cell1;
			aab_pkg::AAB_SEL_STATUS: rd_data = status_byte;
			default:                 rd_data = 8'h00;
		endcase
	end

	// register updates and derived control
	always_comb begin
		bank_nxt = bank_r;
		// the slave has already dropped unmapped, unaligned and lane 0 free writes
		if (wr.en) begin
			unique case (wr.sel)
				aab_pkg::AAB_SEL_AUX_B: begin
					// cell-select sits in another bank; keeping it off while the
					// under- or overvoltage threshold enable is set is up to software
					bank_nxt.aux_b = wr.data; // [R1]
				end
				aab_pkg::AAB_SEL_AUX_C: begin
					// the upper nibble is reserved and never stored
					bank_nxt.aux_c = wr.data & `AAB_AUX_C_WMASK; // [R1] [R8]
				end
				aab_pkg::AAB_SEL_BAL: begin
					// the setup write also clears a pending halt, see below
					bank_nxt.bal = aab_pkg::aab_bal_setup_type'(wr.data); // [R3] [R6] [R7]
				end
				aab_pkg::AAB_SEL_CELL1: begin
					// seven-bit count plus its unit bit; no range limit on the count
					bank_nxt.cell1 = wr.data; // [R4] [R5]
				end
				default: begin
					bank_nxt = bank_r; // status and unmapped ignore writes [R8]
				end
			endcase
		end

		// channel order decode kept registered so outputs stay glitch free
		// decoded from the next setup so the flags move at the same edge as it
		unique case (bank_nxt.bal.balance_channel_order)
			aab_pkg::AAB_ODD_ONLY: begin
				bank_nxt.odd_first = 1'b1; // [R7]
				bank_nxt.two_pass  = 1'b0;
			end
			aab_pkg::AAB_EVEN_ONLY: begin
				bank_nxt.odd_first = 1'b0; // [R7]
				bank_nxt.two_pass  = 1'b0;
			end
			aab_pkg::AAB_ODD_THEN_EVEN: begin
				bank_nxt.odd_first = 1'b1; // [R7]
				bank_nxt.two_pass  = 1'b1;
			end
			aab_pkg::AAB_EVEN_THEN_ODD: begin
				bank_nxt.odd_first = 1'b0; // [R7]
				bank_nxt.two_pass  = 1'b1;
			end
		endcase

		// software is meant to keep both units equal; flag it when not
		// only flagged: the engines run with whatever units software chose
		bank_nxt.mismatch = bank_nxt.bal.duty_unit_sec ^ bank_nxt.cell1.time_unit_sec; // [R3] [R4]

		// any write to the balance setup clears a halt, but a fault in the
		// same cycle wins if halt-on-fault is set both before and after the write
		if (wr.en && wr.sel == aab_pkg::AAB_SEL_BAL)
			bank_nxt.halted = 1'b0;
		if (qualifying_fault && bank_r.bal.halt_balance_on_fault)
			bank_nxt.halted = 1'b1; // [R6]

		// limitation: the bit must already be set when the fault arrives; a fault
		// in the very cycle that writes it to 1 is not latched
		// with halting disabled the engine keeps running through faults
		if (!bank_nxt.bal.halt_balance_on_fault)
			bank_nxt.halted = 1'b0; // [R6]
	end

	// bank register, all fields but odd_first reset to zero
	// the order flags reset to what an all-zero order code decodes to
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bank_r.aux_b     <= `AAB_RST_AUX_B;
			bank_r.aux_c     <= `AAB_RST_AUX_C;
			bank_r.bal       <= `AAB_RST_BAL_SETUP;
			bank_r.cell1     <= `AAB_RST_CELL1;
			bank_r.odd_first <= 1'b1; // order 00 means odd channels
			bank_r.two_pass  <= 1'b0;
			bank_r.halted    <= 1'b0;
			bank_r.mismatch  <= 1'b0;
		end else begin
			bank_r <= bank_nxt;
		end
	end

	// register images towards the engines, straight from the bank flops
	assign aux_conv_b      = bank_r.aux_b;
	assign aux_conv_c      = bank_r.aux_c;
	assign balance_cfg     = bank_r.bal;
	assign cell1_timer     = bank_r.cell1;

	// decoded and live flags, also straight from flops
	assign order_odd_first = bank_r.odd_first;
	assign order_two_pass  = bank_r.two_pass;
	assign balance_halted  = bank_r.halted;
	assign unit_mismatch   = bank_r.mismatch;

endmodule // aab_config_bank
`default_nettype wire

// ===== aab_config_bank_properties.sv
// port-level assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none

module aab_config_bank_properties (
	input wire logic                       sys_clk,
	input wire logic                       arst_n,
	input wire logic                       s_axi_bvalid,
	input wire logic                       qualifying_fault,
	input wire aab_pkg::aab_aux_b_type     aux_conv_b,
	input wire aab_pkg::aab_aux_c_type     aux_conv_c,
	input wire aab_pkg::aab_bal_setup_type balance_cfg,
	input wire aab_pkg::aab_cell_timer_type cell1_timer,
	input wire logic                       order_odd_first,
	input wire logic                       order_two_pass,
	input wire logic                       balance_halted,
	input wire logic                       unit_mismatch
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// decoded flags move at the same edge as the setup, yet are only judged once it settled
	property p_odd_first;
		$stable(balance_cfg) |-> order_odd_first == !balance_cfg[0];
	endproperty
	a_odd_first: assert property (p_odd_first) else $error("odd first flag wrong");

	property p_two_pass;
		$stable(balance_cfg) |-> order_two_pass == balance_cfg[1];
	endproperty
	a_two_pass: assert property (p_two_pass) else $error("two pass flag wrong");

	property p_unit_mismatch;
		$stable(balance_cfg[7]) && $stable(cell1_timer[7])
			|-> unit_mismatch == (balance_cfg[7] ^ cell1_timer[7]);
	endproperty
	a_unit_mismatch: assert property (p_unit_mismatch) else $error("unit mismatch wrong");

	property p_reserved_zero;
		aux_conv_c[7:4] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_halt_set;
		qualifying_fault && balance_cfg[2] |=> balance_halted || !balance_cfg[2];
	endproperty
	a_halt_set: assert property (p_halt_set) else $error("fault did not halt");

	property p_halt_off;
		!balance_cfg[2] && $stable(balance_cfg) |-> !balance_halted;
	endproperty
	a_halt_off: assert property (p_halt_off) else $error("halted while halt is off");

	// sticky until a write response rises for any register
	property p_halt_hold;
		balance_halted && balance_cfg[2] |=> balance_halted || $rose(s_axi_bvalid);
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt dropped early");

	property p_aux_b_write;
		!$stable(aux_conv_b) |-> $rose(s_axi_bvalid);
	endproperty
	a_aux_b_write: assert property (p_aux_b_write) else $error("enables moved alone");
endmodule // aab_config_bank_properties

`default_nettype wire

// ===== aab_config_bank_test.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "aab_map.svh"

module aab_config_bank_test;
	localparam logic [11:0] adr [4] = '{`AAB_IDX_AUX_B << 2, `AAB_IDX_AUX_C << 2,
		`AAB_IDX_BAL_SETUP << 2, `AAB_IDX_CELL1 << 2};
	localparam logic [11:0] adr_stat = `AAB_IDX_STATUS << 2;
	localparam logic [7:0]  msk [4] = '{8'hff, 8'h0f, 8'hff, 8'hff};

	logic        sys_clk = 1'b0, arst_n = 1'b0, qualifying_fault = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        order_odd_first, order_two_pass, balance_halted, unit_mismatch;
	aab_pkg::aab_aux_b_type      aux_conv_b;
	aab_pkg::aab_aux_c_type      aux_conv_c;
	aab_pkg::aab_bal_setup_type  balance_cfg;
	aab_pkg::aab_cell_timer_type cell1_timer;
	int          bad_count = 0, n_tests = 0;

	aab_config_bank aab_config_bank_inst (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.qualifying_fault, .aux_conv_b, .aux_conv_c, .balance_cfg, .cell1_timer,
		.order_odd_first, .order_two_pass, .balance_halted, .unit_mismatch);

	// 40 mhz
	always #12.5 sys_clk = ~sys_clk;

	// case equality so an unknown never passes
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report;
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ready is registered, so its level at the falling edge is what the next rise samples
	task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(negedge sys_clk); while (s_axi_awready !== 1'b1);
				@(posedge sys_clk);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(negedge sys_clk); while (s_axi_wready !== 1'b1);
				@(posedge sys_clk);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
		check("bresp", 32'(s_axi_bresp), 32'(er));
		@(posedge sys_clk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic bus_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
		check("rdata", s_axi_rdata, {24'h00_0000, d});
		check("rresp", 32'(s_axi_rresp), 32'(er));
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(negedge sys_clk);
		check("odd_first", 32'(order_odd_first), 32'h1);
		// reset values, then full and mixed patterns through every writable register
		// cell-select lives outside this bank, so the threshold enables may be set
		for (int i = 0; i < 4; i++) begin
			bus_rd(adr[i], 8'h00, 2'h0);
			bus_wr(adr[i], 8'hff, 4'h1, 2'h0);
			bus_rd(adr[i], msk[i], 2'h0);
			bus_wr(adr[i], 8'h5a, 4'hf, 2'h0);
			bus_rd(adr[i], 8'h5a & msk[i], 2'h0);
		end
		check("aux_b", 32'(aux_conv_b), 32'h5a);
		check("aux_c", 32'(aux_conv_c), 32'h0a);
		check("cell1", 32'(cell1_timer), 32'h5a);
		check("bal", 32'(balance_cfg), 32'h5a);
		// every channel order, duty in seconds against cell timer in minutes
		for (int o = 0; o < 4; o++) begin
			bus_wr(adr[2], 8'h80 | 8'(o), 4'h1, 2'h0);
			@(negedge sys_clk);
			check("odd_first", 32'(order_odd_first), 32'(o[0] == 1'b0));
			check("two_pass", 32'(order_two_pass), 32'(o[1]));
			check("mismatch", 32'(unit_mismatch), 32'h1);
		end
		bus_rd(adr_stat, 8'h02, 2'h0);
		bus_wr(adr[3], 8'hff, 4'h1, 2'h0);
		check("cell1", 32'(cell1_timer), 32'hff);
		bus_rd(adr_stat, 8'h00, 2'h0);
		// a fault is ignored with halt off and latched with halt on
		for (int h = 0; h < 2; h++) begin
			bus_wr(adr[2], 8'(h << 2), 4'h1, 2'h0);
			@(posedge sys_clk);
			qualifying_fault <= 1'b1;
			@(posedge sys_clk);
			qualifying_fault <= 1'b0;
			@(negedge sys_clk);
			check("halted", 32'(balance_halted), 32'(h));
		end
		bus_rd(adr_stat, 8'h03, 2'h0);
		bus_wr(adr[2], 8'h84, 4'h1, 2'h0);
		bus_rd(adr_stat, 8'h00, 2'h0);
		// unmapped, unaligned, masked and status writes leave everything alone
		bus_wr(12'h000, 8'hff, 4'h1, 2'h2);
		bus_rd(12'h000, 8'h00, 2'h2);
		bus_wr(adr[0] + 12'h001, 8'h00, 4'h1, 2'h2);
		bus_wr(adr[0], 8'h00, 4'h0, 2'h0);
		bus_wr(adr_stat, 8'hff, 4'h1, 2'h0);
		bus_rd(adr[0], 8'h5a, 2'h0);
		bus_rd(adr_stat, 8'h00, 2'h0);
		final_report;
	end

	// the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		final_report;
	end
endmodule // aab_config_bank_test

bind aab_config_bank aab_config_bank_properties aab_config_bank_properties_inst (.sys_clk,
	.arst_n, .s_axi_bvalid, .qualifying_fault, .aux_conv_b, .aux_conv_c, .balance_cfg,
	.cell1_timer, .order_odd_first, .order_two_pass, .balance_halted, .unit_mismatch);

`default_nettype wire

// ===== aab_map.svh
// register indices, byte addresses, field positions and reset values of the bank
`ifndef AAB_MAP_SVH
`define AAB_MAP_SVH

// bus geometry
`define AAB_ADDR_W        12
`define AAB_DATA_W        32

// register indices; byte address is four times the index
`define AAB_IDX_AUX_B     12'h10b
`define AAB_IDX_AUX_C     12'h10c
`define AAB_IDX_BAL_SETUP 12'h10d
`define AAB_IDX_CELL1     12'h10e
`define AAB_IDX_STATUS    12'h1f0

// reset values
`define AAB_RST_AUX_B     8'h00
`define AAB_RST_AUX_C     8'h00
`define AAB_RST_BAL_SETUP 8'h00
`define AAB_RST_CELL1     8'h00

// writable bits of the supply enable register, upper nibble reserved
`define AAB_AUX_C_WMASK   8'h0f

// status register bit positions
`define AAB_STAT_HALTED   0
`define AAB_STAT_MISMATCH 1

// axi response codes
`define AAB_RESP_OKAY     2'h0
`define AAB_RESP_SLVERR   2'h2

`endif

// ===== aab_pkg.sv
// types shared by the aux enable and balancing configuration bank
`default_nettype none
`include "aab_map.svh"

package aab_pkg;

	// channel order of the balancing sequence
	typedef enum logic [1:0] {
		AAB_ODD_ONLY      = 2'h0,
		AAB_EVEN_ONLY     = 2'h1,
		AAB_ODD_THEN_EVEN = 2'h2,
		AAB_EVEN_THEN_ODD = 2'h3
	} aab_order_type;

	// register selected by an address
	typedef enum logic [2:0] {
		AAB_SEL_NONE   = 3'h0,
		AAB_SEL_AUX_B  = 3'h1,
		AAB_SEL_AUX_C  = 3'h2,
		AAB_SEL_BAL    = 3'h3,
		AAB_SEL_CELL1  = 3'h4,
		AAB_SEL_STATUS = 3'h5
	} aab_sel_type;

	typedef struct packed {
		logic temp_warn_current_conv_on;
		logic undertemp_threshold_conv_on;
		logic overtemp_threshold_conv_on;
		logic undervolt_threshold_conv_on;
		logic overvolt_threshold_conv_on;
		logic second_bandgap_conv_on;
		logic pin_six_conv_on;
		logic pin_five_conv_on;
	} aab_aux_b_type;

	typedef struct packed {
		logic [3:0] reserved;
		logic       always_on_ref_conv_on;
		logic       core_supply_conv_on;
		logic       sensor_ref_conv_on;
		logic       digital_supply_conv_on;
	} aab_aux_c_type;

	typedef struct packed {
		logic          duty_unit_sec;
		logic [3:0]    duty_period;
		logic          halt_balance_on_fault;
		aab_order_type balance_channel_order;
	} aab_bal_setup_type;

	typedef struct packed {
		logic       time_unit_sec;
		logic [6:0] balance_time;
	} aab_cell_timer_type;

	// register write strobe handed from the bus slave to the bank
	typedef struct packed {
		logic        en;
		aab_sel_type sel;
		logic [7:0]  data;
	} aab_wr_type;

	// byte address to register; unaligned or unknown gives none
	function automatic aab_sel_type aab_decode(input logic [11:0] addr);
		logic [11:0] idx;
		idx = {2'h0, addr[11:2]};
		if (addr[1:0] != 2'h0)
			return AAB_SEL_NONE;
		unique case (idx)
			`AAB_IDX_AUX_B:     return AAB_SEL_AUX_B;
			`AAB_IDX_AUX_C:     return AAB_SEL_AUX_C;
			`AAB_IDX_BAL_SETUP: return AAB_SEL_BAL;
			`AAB_IDX_CELL1:     return AAB_SEL_CELL1;
			`AAB_IDX_STATUS:    return AAB_SEL_STATUS;
			default:            return AAB_SEL_NONE;
		endcase
	endfunction

endpackage
`default_nettype wire
